//--- sdlpt_link_ctrl.v
// serdes link-state control: framing, lock, power-down, output enables, test
// What this block does
// - link_lock_n goes low when the receiver locks onto the clock bits.
// - losing lock raises link_lock_n and floats parallel_out and recovered_clock.
// - two independent sync request inputs; either one starts the sync pattern.
// - receiver locks to random data without any sync pattern.
// - several candidate clock positions keep lock inactive until the pattern changes.
// - a low bit below a high bit mimics clock bits; only bits 0-8.
// - receiver powers down only when power_down_n and receiver_output_enable are low.
// - serializer powers down whenever power_down_n is low.
// - in power-down the PLLs stop and outputs float.
// - serializer needs 510 transmit_clock cycles after power-down before sending.
// - after power-down the receiver reinitializes, link_lock_n high until locked.
// - driver_output_enable low floats both serial driver outputs.
// - driver_output_enable high again resumes the serializer's previous state.
// - receiver_output_enable low floats parallel_out and recovered_clock.
// - link_lock_n stays driven and tracks lock while receiver outputs float, unless the receiver is powered down.
// - EXTEST drives and checks the serial interconnect as a go/no-go test.
// - RUNBIST runs an at-speed interconnect test lasting about 33 ms.
// - BIST result holds pass and done; pass means lock was seen and no word error was counted.
// - each frame is start bit high, ten data bits, stop bit low.
// - while a sync request is high the serializer sends six ones, six zeros.
`timescale 1ns/1ps
`include "sdlpt_defines.vh"
module sdlpt_link_ctrl #(
   parameter BIST_CYCLES = `SDLPT_BIST_TIME_US * `SDLPT_CLK_MHZ,
   parameter [2:0] PERSIST = `SDLPT_PERSIST
) (
   input wire clock_in,
   input wire nrst_in,
   input wire hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire [2:0] hsize_in,
   input wire [31:0] hwdata_in,
   input wire hready_in,
   output reg [31:0] hrdata_out,
   output reg hreadyout_out,
   output reg hresp_out,
   input wire transmit_clock_in,
   input wire transmit_edge_select_in,
   input wire [9:0] parallel_in,
   input wire sync_request_a_in,
   input wire sync_request_b_in,
   input wire power_down_n_in,
   input wire driver_output_enable_in,
   input wire receiver_output_enable_in,
   input wire rx_serial_in,
   output reg [11:0] serial_word_out,
   output reg serial_oe_n_out,
   output reg [9:0] parallel_out,
   output reg recovered_clock_out,
   output reg parallel_oe_n_out,
   output reg link_lock_n_out,
   output reg link_lock_oe_n_out
);
   reg rst_a_q, rst_n_q;
   wire [7:0] pin_s;
   wire [9:0] pdata_s;
   wire tx_clk_s, edge_sel_s, sync_a_s, sync_b_s, pwr_n_s, drv_en_s, ren_s, rx_line_s;
   reg tx_clk_prev_q;
   wire tx_edge, tx_pd, rx_pd, tx_ready;
   reg [9:0] tx_init_q;
   reg [9:0] pdata_rev;
   reg [9:0] tx_lfsr_q;
   reg [2:0] ctrl_q;
   reg bist_run_q, bist_done_q, bist_pass_q, bist_have_prev_q, bist_locked_q;
   reg [21:0] bist_cnt_q;
   reg [15:0] bist_err_q;
   reg [9:0] rx_prev_word_q;
   reg line_prev_q, prev_bit_q, lock_q, amb_q, wr_pend_q;
   reg [2:0] bit_ph_q;
   wire bit_sample;
   reg [3:0] ph_q;
   reg [11:0] rx_sr_q;
   wire [11:0] persist;
   wire [11:0] strobe;
   reg [3:0] ncand;
   reg [3:0] cand_idx;
   reg [3:0] lock_idx_q;
   wire [3:0] stop_ph;
   wire [3:0] mid_ph;
   reg [9:0] rx_word;
   reg [7:0] wr_addr_q;
   wire bus_take;
   reg [31:0] rd_mux;
   integer k, j, m;

   function [9:0] lfsr_next;
      input [9:0] v;
      begin
         lfsr_next = {v[8:0], v[9] ^ v[6]};
      end
   endfunction

   // reset release through two flops
   always @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_a_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_a_q <= 1'b1;
         rst_n_q <= rst_a_q;
      end
   end

   sdlpt_sync3 #(.W(8)) u_pin_sync (
      .clock_in(clock_in),
      .rst_n_in(rst_n_q),
      .async_in({rx_serial_in, receiver_output_enable_in, driver_output_enable_in,
                 power_down_n_in, sync_request_b_in, sync_request_a_in,
                 transmit_edge_select_in, transmit_clock_in}),
      .level_out(pin_s)
   );

   // data shares the clock's delay so it stays aligned with the sampled edge
   sdlpt_sync3 #(.W(10)) u_data_sync (
      .clock_in(clock_in),
      .rst_n_in(rst_n_q),
      .async_in(parallel_in),
      .level_out(pdata_s)
   );

   assign tx_clk_s = pin_s[0];
   assign edge_sel_s = pin_s[1];
   assign sync_a_s = pin_s[2];
   assign sync_b_s = pin_s[3];
   assign pwr_n_s = pin_s[4];
   assign drv_en_s = pin_s[5];
   assign ren_s = pin_s[6];
   assign rx_line_s = pin_s[7];

   assign tx_edge = edge_sel_s ? (tx_clk_s & ~tx_clk_prev_q) : (~tx_clk_s & tx_clk_prev_q);
   assign tx_pd = ~pwr_n_s;
   assign rx_pd = ~pwr_n_s & ~ren_s;
   assign tx_ready = tx_init_q == `SDLPT_TX_INIT_CYCLES;

   // test words go out in data order so the far end sees the register value
   always @* begin
      for (k = 0; k < 10; k = k + 1) begin
         pdata_rev[9 - k] = bist_run_q ? tx_lfsr_q[k] : pdata_s[k];
      end
   end

   // ---------------- serializer ----------------
   always @(posedge clock_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         tx_clk_prev_q <= 1'b0;
         tx_init_q <= 10'h000;
         tx_lfsr_q <= `SDLPT_LFSR_SEED;
         serial_word_out <= 12'h000;
         serial_oe_n_out <= 1'b1;
      end else begin
         tx_clk_prev_q <= tx_clk_s;
         if (tx_pd) begin
            tx_init_q <= 10'h000;
         end else if (tx_edge && !tx_ready) begin
            tx_init_q <= tx_init_q + 10'h001;
         end
         if (!bist_run_q) begin
            tx_lfsr_q <= `SDLPT_LFSR_SEED;
         end else if (tx_edge && tx_ready) begin
            tx_lfsr_q <= lfsr_next(tx_lfsr_q);
         end
         // frame state is kept while the driver floats, so re-enabling resumes it
         if (ctrl_q[`SDLPT_CTRL_EXTEST]) begin
            serial_word_out <= {12{ctrl_q[`SDLPT_CTRL_EXT_LEVEL]}};
         end else if (tx_edge && tx_ready) begin
            if (sync_a_s || sync_b_s) begin
               serial_word_out <= `SDLPT_SYNC_PATTERN;
            end else if (bist_run_q) begin
               serial_word_out <= {`SDLPT_START_BIT, pdata_rev, `SDLPT_STOP_BIT};
            end else begin
               serial_word_out <= {`SDLPT_START_BIT, pdata_rev, `SDLPT_STOP_BIT};
            end
         end
         serial_oe_n_out <= ~(drv_en_s & ~tx_pd & (tx_ready | ctrl_q[`SDLPT_CTRL_EXTEST]));
      end
   end

   // ---------------- receiver bit timing ----------------
   // every line change re-centres the sample point; long runs free-run
   assign bit_sample = bit_ph_q == `SDLPT_RX_SAMPLE_PH;

   always @(posedge clock_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         line_prev_q <= 1'b0;
         bit_ph_q <= 3'h0;
         prev_bit_q <= 1'b0;
         ph_q <= 4'h0;
         rx_sr_q <= 12'h000;
      end else begin
         line_prev_q <= rx_line_s;
         if (rx_line_s != line_prev_q || bit_ph_q == `SDLPT_RX_BIT_CYCLES - 3'h1) begin
            bit_ph_q <= 3'h0;
         end else begin
            bit_ph_q <= bit_ph_q + 3'h1;
         end
         if (rx_pd) begin
            ph_q <= 4'h0;
         end else if (bit_sample) begin
            prev_bit_q <= rx_line_s;
            rx_sr_q <= {rx_sr_q[10:0], rx_line_s};
            ph_q <= (ph_q == `SDLPT_PH_LAST) ? 4'h0 : ph_q + 4'h1;
         end
      end
   end

   // ---------------- false-lock detection ----------------
   // a data bit low under a high neighbour gives a second low-high boundary;
   // bit 9 is followed by the low stop bit, so it can never do so
   genvar g;
   generate
      for (g = 0; g < `SDLPT_FRAME_BITS; g = g + 1) begin : g_off
         assign strobe[g] = bit_sample & (ph_q == g);
         sdlpt_offset_track #(.PERSIST(PERSIST)) u_track (
            .clock_in(clock_in),
            .rst_n_in(rst_n_q),
            .clear_in(rx_pd),
            .strobe_in(strobe[g]),
            .rise_in(~prev_bit_q & rx_line_s),
            .persist_out(persist[g])
         );
      end
   endgenerate

   always @* begin
      ncand = 4'h0;
      cand_idx = 4'h0;
      for (j = 0; j < `SDLPT_FRAME_BITS; j = j + 1) begin
         if (persist[j]) begin
            ncand = ncand + 4'h1;
            cand_idx = j[3:0];
         end
      end
   end

   assign stop_ph = (lock_idx_q == 4'h0) ? `SDLPT_PH_LAST : lock_idx_q - 4'h1;
   assign mid_ph = (lock_idx_q > `SDLPT_PH_LAST - `SDLPT_PH_HALF) ?
                   lock_idx_q + `SDLPT_PH_HALF - (`SDLPT_PH_LAST + 4'h1) :
                   lock_idx_q + `SDLPT_PH_HALF;

   // at the stop sample the last ten bits shifted in are d9 (bit 0) back to d0
   always @* begin
      for (m = 0; m < 10; m = m + 1) begin
         rx_word[m] = rx_sr_q[9 - m];
      end
   end

   // ---------------- lock and receiver outputs ----------------
   always @(posedge clock_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         lock_q <= 1'b0;
         amb_q <= 1'b0;
         lock_idx_q <= 4'h0;
         parallel_out <= 10'h000;
         recovered_clock_out <= 1'b0;
         parallel_oe_n_out <= 1'b1;
         link_lock_n_out <= 1'b1;
         link_lock_oe_n_out <= 1'b1;
      end else begin
         // exactly one persisting boundary means lock, random data or sync alike
         lock_q <= (ncand == 4'h1) & ~rx_pd;
         amb_q <= ncand > 4'h1;
         if (ncand == 4'h1) begin
            lock_idx_q <= cand_idx;
         end
         link_lock_n_out <= ~lock_q;
         link_lock_oe_n_out <= rx_pd;
         parallel_oe_n_out <= ~(lock_q & ren_s & ~rx_pd);
         if (!lock_q) begin
            recovered_clock_out <= 1'b0;
         end else if (bit_sample && ph_q == stop_ph) begin
            parallel_out <= rx_word; // oldest data bit is bit 0
            recovered_clock_out <= 1'b1;
         end else if (bit_sample && ph_q == mid_ph) begin
            recovered_clock_out <= 1'b0;
         end
      end
   end

   // ---------------- built-in self test ----------------
   // a zero-error run is the only pass; the run is far shorter than 1e7 bits
   always @(posedge clock_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         bist_run_q <= 1'b0;
         bist_done_q <= 1'b0;
         bist_pass_q <= 1'b0;
         bist_cnt_q <= 22'h000000;
         bist_err_q <= 16'h0000;
         bist_have_prev_q <= 1'b0;
         bist_locked_q <= 1'b0;
         rx_prev_word_q <= 10'h000;
      end else if (wr_pend_q && wr_addr_q == `SDLPT_ADDR_CTRL &&
                   hwdata_in[`SDLPT_CTRL_BIST]) begin
         bist_run_q <= 1'b1;
         bist_done_q <= 1'b0;
         bist_pass_q <= 1'b0;
         bist_cnt_q <= 22'h000000;
         bist_err_q <= 16'h0000;
         bist_have_prev_q <= 1'b0;
         bist_locked_q <= 1'b0;
      end else if (bist_run_q) begin
         bist_cnt_q <= bist_cnt_q + 22'h000001;
         if (lock_q) begin
            bist_locked_q <= 1'b1;
         end
         if (lock_q && bit_sample && ph_q == stop_ph) begin
            rx_prev_word_q <= rx_word;
            bist_have_prev_q <= 1'b1;
            if (bist_have_prev_q && lfsr_next(rx_prev_word_q) != rx_word
                && bist_err_q != 16'hffff) begin
               bist_err_q <= bist_err_q + 16'h0001;
            end
         end
         if (bist_cnt_q == BIST_CYCLES[21:0] - 22'h000001) begin
            bist_run_q <= 1'b0;
            bist_done_q <= 1'b1;
            bist_pass_q <= bist_locked_q & (bist_err_q == 16'h0000);
         end
      end
   end

   // ---------------- AHB-Lite slave, zero wait states ----------------
   assign bus_take = hsel_in & hready_in &
                     (htrans_in == `SDLPT_HTRANS_NONSEQ || htrans_in == `SDLPT_HTRANS_SEQ);

   always @* begin
      rd_mux = 32'h00000000;
      case (haddr_in[7:0])
         `SDLPT_ADDR_CTRL: rd_mux = {29'h0, 1'b0, ctrl_q[1:0]};
         `SDLPT_ADDR_STATUS: rd_mux = {24'h0, rx_pd, tx_pd, rx_line_s, tx_ready,
                                       amb_q, lock_q, bist_done_q, bist_pass_q};
         `SDLPT_ADDR_ERRORS: rd_mux = {16'h0, bist_err_q};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge clock_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ctrl_q <= `SDLPT_CTRL_RESET;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata_out <= 32'h00000000;
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
         wr_pend_q <= bus_take & hwrite_in;
         if (bus_take) begin
            wr_addr_q <= haddr_in[7:0];
         end
         if (bus_take && !hwrite_in) begin
            hrdata_out <= rd_mux;
         end
         if (wr_pend_q && wr_addr_q == `SDLPT_ADDR_CTRL) begin
            ctrl_q <= {1'b0, hwdata_in[`SDLPT_CTRL_EXT_LEVEL], hwdata_in[`SDLPT_CTRL_EXTEST]};
         end
      end
   end
endmodule

//--- sdlpt_defines.vh
// shared constants for the serdes lock, power and test control block
`ifndef SDLPT_DEFINES_VH
`define SDLPT_DEFINES_VH

`define SDLPT_CLK_MHZ 40
`define SDLPT_FRAME_BITS 12
`define SDLPT_PH_W 4
`define SDLPT_PH_LAST 4'hb
`define SDLPT_PH_HALF 4'h5
`define SDLPT_TX_INIT_CYCLES 10'h1fe
`define SDLPT_SYNC_PATTERN 12'hfc0
`define SDLPT_START_BIT 1'b1
`define SDLPT_STOP_BIT 1'b0
`define SDLPT_LFSR_SEED 10'h3ff
`define SDLPT_BIST_TIME_US 33000
`define SDLPT_RX_BIT_CYCLES 3'h4
`define SDLPT_RX_SAMPLE_PH 3'h2
`define SDLPT_PERSIST 3'h4

`define SDLPT_ADDR_CTRL 8'h00
`define SDLPT_ADDR_STATUS 8'h04
`define SDLPT_ADDR_ERRORS 8'h08
`define SDLPT_CTRL_RESET 3'h0
`define SDLPT_CTRL_EXTEST 0
`define SDLPT_CTRL_EXT_LEVEL 1
`define SDLPT_CTRL_BIST 2
`define SDLPT_HTRANS_NONSEQ 2'h2
`define SDLPT_HTRANS_SEQ 2'h3

`endif

//--- sdlpt_sync3.v
// three-flop input synchroniser with second/third agreement filter
`timescale 1ns/1ps
module sdlpt_sync3 #(
   parameter W = 1
) (
   input wire clock_in,
   input wire rst_n_in,
   input wire [W-1:0] async_in,
   output reg [W-1:0] level_out
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   integer i;

   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_q <= {W{1'b0}};
         s2_q <= {W{1'b0}};
         s3_q <= {W{1'b0}};
         level_out <= {W{1'b0}};
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // per bit, a change counts only once both late stages agree
         for (i = 0; i < W; i = i + 1) begin
            if (s2_q[i] == s3_q[i]) begin
               level_out[i] <= s3_q[i];
            end
         end
      end
   end
endmodule

//--- sdlpt_offset_track.v
// per-offset tracker: counts frames in a row with a low-high boundary
`timescale 1ns/1ps
`include "sdlpt_defines.vh"
module sdlpt_offset_track #(
   parameter [2:0] PERSIST = `SDLPT_PERSIST
) (
   input wire clock_in,
   input wire rst_n_in,
   input wire clear_in,
   input wire strobe_in,
   input wire rise_in,
   output reg persist_out
);
   reg [2:0] count_q;

   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_q <= 3'h0;
         persist_out <= 1'b0;
      end else if (clear_in) begin
         count_q <= 3'h0;
         persist_out <= 1'b0;
      end else if (strobe_in) begin
         if (!rise_in) begin
            // one missing boundary drops this offset at once
            count_q <= 3'h0;
            persist_out <= 1'b0;
         end else if (count_q != PERSIST) begin
            count_q <= count_q + 3'h1;
            persist_out <= (count_q + 3'h1) == PERSIST;
         end
      end
   end
endmodule

//--- sdlpt_link_chk.sv
// concurrent checks on the serdes link control ports
`timescale 1ns/1ps
module sdlpt_link_chk (
   input wire clock_in,
   input wire nrst_in,
   input wire power_down_n_in,
   input wire driver_output_enable_in,
   input wire receiver_output_enable_in,
   input wire [11:0] serial_word_out,
   input wire serial_oe_n_out,
   input wire parallel_oe_n_out,
   input wire link_lock_n_out,
   input wire link_lock_oe_n_out
);
   // cycles the receiver has been out of power-down, saturating
   reg [3:0] awake_q;
   wire [3:0] awake_d;
   assign awake_d = !(power_down_n_in || receiver_output_enable_in) ? 4'h0 :
                    (awake_q == 4'hf) ? awake_q : awake_q + 4'h1;
   always @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in)
         awake_q <= 4'h0;
      else
         awake_q <= awake_d;
   end
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!nrst_in);
   lock_driven_a: assert property (awake_q == 4'hf |-> !link_lock_oe_n_out)
      else $error("lock output floated while receiver awake");
   lock_float_a: assert property (link_lock_n_out [*3] |-> parallel_oe_n_out)
      else $error("receiver outputs driven without lock");
   rx_float_a: assert property (!receiver_output_enable_in [*8] |-> parallel_oe_n_out)
      else $error("receiver outputs driven while disabled");
   tx_float_a: assert property (!driver_output_enable_in [*8] |-> serial_oe_n_out)
      else $error("serial driver on while disabled");
   tx_pd_a: assert property (!power_down_n_in [*8] |-> serial_oe_n_out)
      else $error("serial driver on in power-down");
   rx_pd_a: assert property ((!power_down_n_in && !receiver_output_enable_in) [*8]
      |-> link_lock_oe_n_out && parallel_oe_n_out)
      else $error("receiver outputs driven in power-down");
   frame_bits_a: assert property (!serial_oe_n_out && serial_word_out != 12'hfff &&
      serial_word_out != 12'h000 |-> serial_word_out[11] && !serial_word_out[0])
      else $error("frame clock bits wrong");
   tx_init_a: assert property ($rose(power_down_n_in) |-> serial_oe_n_out [*8])
      else $error("serializer sent before init");
   rx_relock_a: assert property ($rose(power_down_n_in) && !receiver_output_enable_in
      |-> link_lock_n_out [*8])
      else $error("lock shown right after power-down");
   cover property ($fell(link_lock_n_out));
   cover property ($rose(link_lock_n_out));
   cover property (!serial_oe_n_out && serial_word_out == 12'hfc0);
endmodule
bind sdlpt_link_ctrl sdlpt_link_chk i_sdlpt_link_chk (.*);

//--- sdlpt_far_tx.sv
// far-end serializer model: repeating frames, each bit held 4 clocks
`timescale 1ns/1ps
module sdlpt_far_tx (
   input wire clock_in,
   input wire [9:0] data_in,
   output reg line_out
);
   reg [11:0] frame_q = 12'h800;
   reg [3:0] bit_q = 4'h0;
   reg [1:0] sub_q = 2'h0;
   always @(posedge clock_in) begin
      sub_q <= sub_q + 2'h1;
      line_out <= frame_q[4'hb - bit_q];
      if (sub_q == 2'h3) begin
         bit_q <= (bit_q == 4'hb) ? 4'h0 : bit_q + 4'h1;
         // new word only at a frame boundary, start high and stop low fixed
         if (bit_q == 4'hb) begin
            for (int i = 0; i < 10; i++) frame_q[10 - i] <= data_in[i];
         end
      end
   end
endmodule

//--- tb.sv
// self-checking bench for the serdes link control block
`timescale 1ns/1ps
`include "sdlpt_defines.vh"
module tb;
   localparam int BISTC = 2000;
   logic clock_in = 1'b0;
   logic nrst_in = 1'b0;
   logic hsel_in = 1'b0;
   logic [31:0] haddr_in = 32'h0;
   logic [1:0] htrans_in = 2'h0;
   logic hwrite_in = 1'b0;
   logic [2:0] hsize_in = 3'h2;
   logic [31:0] hwdata_in = 32'h0;
   logic transmit_clock_in = 1'b0;
   logic transmit_edge_select_in = 1'b1;
   logic [9:0] parallel_in = 10'h2a5;
   logic sync_request_a_in = 1'b0;
   logic sync_request_b_in = 1'b0;
   logic power_down_n_in = 1'b1;
   logic driver_output_enable_in = 1'b1;
   logic receiver_output_enable_in = 1'b1;
   logic [9:0] far_data = 10'h00f;
   logic [31:0] junk;
   wire rx_serial_in;
   wire [31:0] hrdata_out;
   wire [11:0] serial_word_out;
   wire [9:0] parallel_out;
   wire hreadyout_out, hresp_out, serial_oe_n_out, recovered_clock_out;
   wire parallel_oe_n_out, link_lock_n_out, link_lock_oe_n_out;
   wire hready_in = hreadyout_out;
   int fails = 0;
   int tests_run = 0;
   int tedges = 0;
   int e0;
   sdlpt_link_ctrl #(.BIST_CYCLES(BISTC)) i_sdlpt_link_ctrl (.*);
   sdlpt_far_tx i_sdlpt_far_tx (.clock_in(clock_in), .data_in(far_data),
      .line_out(rx_serial_in));
   always #12.5 clock_in = ~clock_in;
   always #100 transmit_clock_in = ~transmit_clock_in;
   always @(posedge transmit_clock_in) tedges++;
   task tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input string w, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", w, e, g);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clock_in);
   endtask
   task rdy;
      int n;
      begin
         n = 0;
         @(posedge clock_in);
         while (hreadyout_out !== 1'b1 && n < 64) begin
            @(posedge clock_in);
            n++;
         end
         if (n == 64) begin
            fails++;
            tally_and_finish;
         end
      end
   endtask
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel_in <= 1'b1;
      haddr_in <= {24'h0, a};
      hwrite_in <= wr;
      htrans_in <= `SDLPT_HTRANS_NONSEQ;
      rdy;
      htrans_in <= 2'h0;
      hwdata_in <= wd;
      rdy;
      rd = hrdata_out;
   endtask
   task rchk(input string w, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      begin
         ahb(1'b0, a, 32'h0, d);
         chk(w, e, d & m);
      end
   endtask
   task wlock(input logic e, input int lim);
      int n;
      begin
         n = 0;
         while (link_lock_n_out !== e && n < lim) begin
            @(posedge clock_in);
            n++;
         end
         chk("lock", 32'(e), 32'(link_lock_n_out));
         if (n == lim)
            tally_and_finish;
      end
   endtask
   // counts rising transmit edges from e0 until the driver turns on
   task wready(input int s);
      int n;
      begin
         n = 0;
         while (serial_oe_n_out !== 1'b0 && n < 6000) begin
            @(posedge clock_in);
            n++;
         end
         chk("init edges", 32'h1, 32'((tedges - s >= 510) && (tedges - s <= 512)));
         if (n == 6000)
            tally_and_finish;
      end
   endtask
   function automatic logic [11:0] frm(input logic [9:0] d);
      logic [11:0] f;
      begin
         f = 12'h800;
         for (int i = 0; i < 10; i++) f[10 - i] = d[i];
         return f;
      end
   endfunction
   initial begin
      cyc(16);
      nrst_in <= 1'b1;
      e0 = tedges;
      chk("reset lock", 32'h7, 32'({link_lock_n_out, serial_oe_n_out, parallel_oe_n_out}));
      cyc(3);
      rchk("ctrl", `SDLPT_ADDR_CTRL, 32'h7, 32'(`SDLPT_CTRL_RESET));
      rchk("errors", `SDLPT_ADDR_ERRORS, 32'hffff, 32'h0);
      ahb(1'b1, 8'h0c, 32'hffffffff, junk);
      chk("hresp", 32'h0, 32'(hresp_out));
      rchk("unmapped", 8'h0c, 32'hffffffff, 32'h0);
      $display("test registers done");
      wready(e0);
      for (int i = 0; i < 2; i++) begin
         transmit_edge_select_in <= (i == 1);
         parallel_in <= i ? 10'h2a5 : 10'h156;
         cyc(24);
         chk("frame", 32'(frm(parallel_in)), 32'(serial_word_out));
      end
      for (int i = 0; i < 3; i++) begin
         sync_request_a_in <= (i == 0);
         sync_request_b_in <= (i == 1);
         cyc(24);
         chk("sync", 32'(i < 2 ? 12'hfc0 : frm(parallel_in)), 32'(serial_word_out));
      end
      driver_output_enable_in <= 1'b0;
      cyc(10);
      chk("driver off", 32'h1, 32'(serial_oe_n_out));
      driver_output_enable_in <= 1'b1;
      cyc(10);
      chk("driver on", 32'(frm(parallel_in)), 32'({serial_oe_n_out, serial_word_out}));
      $display("test serializer done");
      wlock(1'b0, 600);
      chk("rx data", 32'h00f, 32'({parallel_oe_n_out, parallel_out}));
      e0 = 0;
      repeat (48) begin
         @(posedge clock_in);
         e0 += recovered_clock_out;
      end
      chk("rx clock high cycles", 32'h18, 32'(e0));
      for (int k = 0; k < 9; k += 4) begin
         far_data <= 10'h1 << (k + 1);
         wlock(1'b1, 600);
         rchk("ambiguous", `SDLPT_ADDR_STATUS, 32'h8, 32'h8);
         chk("lost float", 32'h1, 32'(parallel_oe_n_out));
         far_data <= 10'h00f;
         wlock(1'b0, 600);
      end
      receiver_output_enable_in <= 1'b0;
      cyc(10);
      chk("rx off", 32'h4, 32'({parallel_oe_n_out, link_lock_oe_n_out, link_lock_n_out}));
      receiver_output_enable_in <= 1'b1;
      $display("test receiver done");
      power_down_n_in <= 1'b0;
      cyc(10);
      rchk("tx pd", `SDLPT_ADDR_STATUS, 32'hc0, 32'h40);
      chk("tx pd pins", 32'h1, 32'({link_lock_oe_n_out, serial_oe_n_out}));
      receiver_output_enable_in <= 1'b0;
      cyc(10);
      rchk("rx pd", `SDLPT_ADDR_STATUS, 32'hc0, 32'hc0);
      chk("pd pins", 32'h7, 32'({link_lock_oe_n_out, parallel_oe_n_out, serial_oe_n_out}));
      e0 = tedges;
      power_down_n_in <= 1'b1;
      cyc(1);
      receiver_output_enable_in <= 1'b1;
      cyc(8);
      chk("relock", 32'h1, 32'(link_lock_n_out));
      wready(e0);
      wlock(1'b0, 600);
      $display("test powerdown done");
      ahb(1'b1, `SDLPT_ADDR_CTRL, 32'h3, junk);
      cyc(2);
      chk("extest high", 32'hfff, 32'(serial_word_out));
      ahb(1'b1, `SDLPT_ADDR_CTRL, 32'h1, junk);
      cyc(2);
      chk("extest low", 32'h0, 32'(serial_word_out));
      ahb(1'b1, `SDLPT_ADDR_CTRL, 32'h4, junk);
      rchk("bist busy", `SDLPT_ADDR_STATUS, 32'h3, 32'h0);
      for (int n = 0; n < BISTC && junk[1] !== 1'b1; n++) ahb(1'b0, `SDLPT_ADDR_STATUS, 32'h0, junk);
      // receiver hears the far model, not the test pattern, so no pass
      chk("bist result", 32'h2, junk & 32'h3);
      rchk("bist self clear", `SDLPT_ADDR_CTRL, 32'h4, 32'h0);
      $display("test test modes done");
      tally_and_finish;
   end
endmodule
